// >>> design/mem_prot.sv
// Memory map decoder, access timing and flash protection
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

module mem_prot #(
    parameter bit         LARGE  = 1'b1,
    parameter int         CAL_N  = 8,
    // Identification values are arbitrary
    parameter logic [7:0] ID0    = 8'h5a,
    parameter logic [7:0] ID1    = 8'h01,
    parameter logic [7:0] ID2    = 8'h02,
    parameter logic [7:0] REV    = 8'h00
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        dat_re_i,
    input  wire logic        dat_we_i,
    input  wire logic        dat_short_i,
    input  wire logic        dat_burst_i,
    input  wire logic [1:0]  dat_op_i,
    input  wire logic [2:0]  dat_bit_i,
    input  wire logic [15:0] dat_addr_i,
    input  wire logic [7:0]  dat_wdata_i,
    output logic             dat_busy_o,
    output logic             dat_done_o,
    output logic             dat_err_o,
    output logic [7:0]       dat_rdata_o,
    output logic             tgt_io_o,
    output logic             tgt_ee_o,
    output logic             tgt_sram_o,
    output logic             tgt_we_o,
    output logic [15:0]      tgt_addr_o,
    output logic [7:0]       tgt_wdata_o,
    output logic [1:0]       tgt_op_o,
    output logic [2:0]       tgt_bit_o,
    input  wire logic [7:0]  tgt_rdata_i,
    input  wire logic        fl_req_i,
    input  wire logic        fl_prog_i,
    input  wire logic [1:0]  fl_cmd_i,
    input  wire logic [1:0]  fl_space_i,
    input  wire logic [15:0] fl_addr_i,
    input  wire logic [15:0] fl_pc_i,
    output logic             fl_ok_o,
    output logic             fl_deny_o,
    output logic [8:0]       fl_page_o,
    output logic [6:0]       fl_word_o,
    input  wire logic        pgm_lock_we_i,
    input  wire logic        pgm_fuse_we_i,
    input  wire logic        pgm_fuse_sel_i,
    input  wire logic [7:0]  pgm_data_i,
    input  wire logic        chip_erase_i,
    input  wire logic        erase_done_i,
    output logic             flash_erase_o,
    output logic             cal_load_o,
    output logic [7:0]       cal_idx_o,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    output logic [7:0]       reg_rdata_o
);

    if (CAL_N < 1 || CAL_N > 256)
    begin : g_bad_cal
        $error("CAL_N must lie in 1..256");
    end

    localparam logic [7:0] CAL_LAST = 8'(CAL_N - 1);

    typedef struct packed {
        mem_prot_pkg::mstate_t st;
        logic [7:0]            cal_idx;
        logic                  cal_load;
        logic                  erase;
        logic [7:0]            lock;
        logic [7:0]            fuse0;
        logic [7:0]            fuse1;
        logic                  ee_map;
        logic [15:0][7:0]      gp;
        logic                  busy;
        logic [1:0]            cnt;
        logic [2:0]            str;
        logic                  ext;
        logic                  we;
        logic [15:0]           taddr;
        logic [7:0]            twd;
        logic [1:0]            top;
        logic [2:0]            tbit;
        logic                  done;
        logic                  err;
        logic [7:0]            rdata;
        logic                  fok;
        logic                  fdeny;
        logic [8:0]            flash_page_number;
        logic [6:0]            flash_word_in_page;
        logic [7:0]            rrd;
    } state_t;

    state_t s;
    state_t next_s;

    // Flash region of a word address; used for target and for fetch origin
    function automatic mem_prot_pkg::region_t region_of(input logic [15:0] a);
        logic [15:0] app_top;
        logic [15:0] tbl_top;
        logic [15:0] boot_top;
        app_top  = LARGE ? mem_prot_pkg::APP_TOP_L : mem_prot_pkg::APP_TOP_S;
        tbl_top  = LARGE ? mem_prot_pkg::TBL_TOP_L : mem_prot_pkg::TBL_TOP_S;
        boot_top = LARGE ? mem_prot_pkg::BOOT_TOP_L : mem_prot_pkg::BOOT_TOP_S;
        if (a <= app_top)
            region_of = mem_prot_pkg::RG_APP;
        else if (a <= tbl_top)
            region_of = mem_prot_pkg::RG_TBL;
        else if (a <= boot_top)
            region_of = mem_prot_pkg::RG_BOOT;
        else
            region_of = mem_prot_pkg::RG_NONE;
    endfunction

    // Two-bit lock field of a region; zero bits block
    function automatic logic [1:0] lock_of(input logic [7:0] lk,
                                           input mem_prot_pkg::region_t r);
        case (r)
            mem_prot_pkg::RG_APP:  lock_of = lk[mem_prot_pkg::LK_APP +: 2];
            mem_prot_pkg::RG_TBL:  lock_of = lk[mem_prot_pkg::LK_TBL +: 2];
            mem_prot_pkg::RG_BOOT: lock_of = lk[mem_prot_pkg::LK_BOOT +: 2];
            default:               lock_of = 2'h0;
        endcase
    endfunction

    // Combinational scratch
    logic [15:0]           a;
    logic [15:0]           sram_top;
    mem_prot_pkg::dtgt_t   t;
    logic [1:0]            cyc;
    logic                  gp_hit;
    logic [3:0]            gi;
    logic [7:0]            gv;
    mem_prot_pkg::region_t rg;
    mem_prot_pkg::region_t pr;
    logic [1:0]            lk;
    logic                  wr_ok;
    logic                  fl_wr;

    always_comb
    begin
        next_s      = s;
        next_s.done = 1'b0;
        next_s.err  = 1'b0;
        next_s.fok  = 1'b0;
        next_s.fdeny = 1'b0;
        next_s.cal_load = 1'b0;
        a        = 16'h0000;
        t        = mem_prot_pkg::T_NONE;
        cyc      = mem_prot_pkg::IO_CYC;
        gp_hit   = 1'b0;
        gi       = 4'h0;
        gv       = 8'h00;
        sram_top = LARGE ? mem_prot_pkg::SRAM_TOP_L : mem_prot_pkg::SRAM_TOP_S;
        rg       = region_of(fl_addr_i);
        pr       = region_of(fl_pc_i);
        lk       = lock_of(s.lock, rg);
        wr_ok    = 1'b0;
        fl_wr    = 1'b0;

        // Mode sequencer: calibration walk after reset, chip erase
        case (s.st)
            mem_prot_pkg::M_CAL:
            begin
                next_s.cal_load = 1'b1;
                next_s.cal_idx  = s.cal_load ? s.cal_idx + 8'h01 : s.cal_idx;
                if (s.cal_load && s.cal_idx == CAL_LAST)
                begin
                    next_s.cal_load = 1'b0;
                    next_s.st       = mem_prot_pkg::M_RUN;
                end
            end
            mem_prot_pkg::M_RUN:
            begin
                if (chip_erase_i)
                begin
                    next_s.erase = 1'b1;
                    next_s.st    = mem_prot_pkg::M_ERASE;
                end
            end
            mem_prot_pkg::M_ERASE:
            begin
                // Locks hold until the flash array reports erased
                if (erase_done_i)
                begin
                    next_s.erase = 1'b0;
                    next_s.lock  = mem_prot_pkg::LOCK_RST;
                    next_s.st    = mem_prot_pkg::M_RUN;
                end
            end
            default:
                next_s.st = mem_prot_pkg::M_RUN;
        endcase

        // Lock writes only clear bits, so protection relaxes only on reset or when a chip erase completes
        if (s.st != mem_prot_pkg::M_ERASE)
        begin
            if (pgm_lock_we_i)
                next_s.lock = next_s.lock & pgm_data_i;
            if (reg_we_i && reg_addr_i == mem_prot_pkg::REG_LOCK)
                next_s.lock = next_s.lock & reg_wdata_i;
        end

        // Fuses change only from the programmer side
        if (pgm_fuse_we_i && !pgm_fuse_sel_i)
            next_s.fuse0 = pgm_data_i;
        if (pgm_fuse_we_i && pgm_fuse_sel_i)
            next_s.fuse1 = pgm_data_i;

        if (reg_we_i && reg_addr_i == mem_prot_pkg::REG_CTRL)
            next_s.ee_map = reg_wdata_i[mem_prot_pkg::CTRL_EE_MAP];

        // Register read data, one cycle after the strobe
        next_s.rrd = 8'h00;
        if (reg_re_i)
        begin
            if (reg_addr_i == mem_prot_pkg::REG_LOCK)
                next_s.rrd = s.lock;
            else if (reg_addr_i == mem_prot_pkg::REG_FUSE0)
                next_s.rrd = s.fuse0;
            else if (reg_addr_i == mem_prot_pkg::REG_FUSE1)
                next_s.rrd = s.fuse1;
            else if (reg_addr_i == mem_prot_pkg::REG_CTRL)
                next_s.rrd = {7'h00, s.ee_map};
            else if (reg_addr_i == mem_prot_pkg::REG_ID0)
                next_s.rrd = ID0;
            else if (reg_addr_i == mem_prot_pkg::REG_ID1)
                next_s.rrd = ID1;
            else if (reg_addr_i == mem_prot_pkg::REG_ID2)
                next_s.rrd = ID2;
            else if (reg_addr_i == mem_prot_pkg::REG_REV)
                next_s.rrd = REV;
            else if (reg_addr_i == mem_prot_pkg::REG_STAT)
            begin
                next_s.rrd[mem_prot_pkg::STAT_CAL]   = s.st == mem_prot_pkg::M_CAL;
                next_s.rrd[mem_prot_pkg::STAT_ERASE] = s.erase;
            end
        end

        // Flash access check, answered the next cycle
        if (fl_req_i)
        begin
            fl_wr = fl_cmd_i != mem_prot_pkg::FC_READ;
            // Self-programming only counts from boot code; any target word
            wr_ok = fl_prog_i || pr == mem_prot_pkg::RG_BOOT;
            case (mem_prot_pkg::space_t'(fl_space_i))
                mem_prot_pkg::SP_MAIN:
                    next_s.fok = rg != mem_prot_pkg::RG_NONE &&
                                 (fl_wr ? (wr_ok && lk[mem_prot_pkg::LK_WR])
                                        : lk[mem_prot_pkg::LK_RD]);
                mem_prot_pkg::SP_USIG:
                    next_s.fok = !fl_wr || wr_ok;
                mem_prot_pkg::SP_PSIG:
                    next_s.fok = !fl_wr;
                default:
                    next_s.fok = !fl_wr || (fl_prog_i &&
                                 fl_cmd_i == mem_prot_pkg::FC_WRITE);
            endcase
            if (s.st != mem_prot_pkg::M_RUN)
                next_s.fok = 1'b0;
            next_s.fdeny = !next_s.fok;
            next_s.flash_page_number = fl_addr_i[15:mem_prot_pkg::FLASH_WORD_IN_PAGE_W];
            next_s.flash_word_in_page = fl_addr_i[mem_prot_pkg::FLASH_WORD_IN_PAGE_W-1:0];
        end

        // Data-space access sequencing
        if (s.busy)
        begin
            if (s.cnt == 2'h0)
            begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
                {next_s.ext, next_s.str} = 4'h0;
                next_s.we   = 1'b0;
                if (s.ext && !s.we)
                    next_s.rdata = tgt_rdata_i;
            end
            else
                next_s.cnt = s.cnt - 2'h1;
        end
        else if (dat_re_i || dat_we_i)
        begin
            // Short form carries only six address bits
            a = dat_short_i ? {10'h000, dat_addr_i[mem_prot_pkg::SHORT_IO_W-1:0]}
                            : dat_addr_i;
            if (a <= mem_prot_pkg::IO_TOP)
            begin
                t   = mem_prot_pkg::T_IO;
                cyc = mem_prot_pkg::IO_CYC;
            end
            else if (a >= mem_prot_pkg::EE_BASE && a <= mem_prot_pkg::EE_TOP &&
                     s.ee_map)
            begin
                t   = mem_prot_pkg::T_EE;
                cyc = dat_we_i ? mem_prot_pkg::EE_LD_CYC :
                      dat_burst_i ? mem_prot_pkg::EE_BURST_CYC
                                  : mem_prot_pkg::EE_RD_CYC;
            end
            else if (a >= mem_prot_pkg::SRAM_BASE && a <= sram_top)
            begin
                t   = mem_prot_pkg::T_SRAM;
                cyc = dat_we_i ? mem_prot_pkg::SRAM_WR_CYC
                               : mem_prot_pkg::SRAM_RD_CYC;
            end
            gp_hit = t == mem_prot_pkg::T_IO && a <= mem_prot_pkg::GP_TOP;
            gi     = a[3:0];
            gv     = s.gp[gi];

            if (dat_op_i != mem_prot_pkg::OP_NONE && a > mem_prot_pkg::BIT_IO_TOP)
                next_s.err = 1'b1;
            else
            begin
                next_s.busy  = 1'b1;
                next_s.cnt   = cyc - 2'h1;
                next_s.ext   = t != mem_prot_pkg::T_NONE && !gp_hit;
                next_s.str   = next_s.ext ? 3'((4'h1 << t) >> 1) : 3'h0; // One-hot strobes
                next_s.we    = dat_we_i && next_s.ext;
                next_s.top   = dat_op_i;
                next_s.tbit  = dat_bit_i;
                next_s.twd   = dat_wdata_i;
                // Targets see region-relative addresses; EEPROM low bits pick byte
                next_s.taddr = t == mem_prot_pkg::T_EE ? a - mem_prot_pkg::EE_BASE :
                               t == mem_prot_pkg::T_SRAM ? a - mem_prot_pkg::SRAM_BASE
                                                         : a;
                // Reserved gap and unmapped EEPROM read as zero
                next_s.rdata = gp_hit ? gv : 8'h00;
                if (gp_hit && dat_we_i)
                    next_s.gp[gi] = dat_wdata_i;
                else if (gp_hit && dat_op_i == mem_prot_pkg::OP_SET)
                    next_s.gp[gi] = gv | (8'h01 << dat_bit_i);
                else if (gp_hit && dat_op_i == mem_prot_pkg::OP_CLR)
                    next_s.gp[gi] = gv & ~(8'h01 << dat_bit_i);
            end
        end
    end

    // Single state register; reset values are constants only
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s       <= '0;
            s.st    <= mem_prot_pkg::M_CAL;
            s.lock  <= mem_prot_pkg::LOCK_RST;
            s.fuse0 <= mem_prot_pkg::FUSE_RST;
            s.fuse1 <= mem_prot_pkg::FUSE_RST;
        end
        else
            s <= next_s;
    end

    // Outputs straight from state flops
    assign dat_busy_o    = s.busy;
    assign dat_done_o    = s.done;
    assign dat_err_o     = s.err;
    assign dat_rdata_o   = s.rdata;
    assign tgt_io_o      = s.str[0];
    assign tgt_ee_o      = s.str[1];
    assign tgt_sram_o    = s.str[2];
    assign tgt_we_o      = s.we;
    assign tgt_addr_o    = s.taddr;
    assign tgt_wdata_o   = s.twd;
    assign tgt_op_o      = s.top;
    assign tgt_bit_o     = s.tbit;
    assign fl_ok_o       = s.fok;
    assign fl_deny_o     = s.fdeny;
    assign fl_page_o     = s.flash_page_number;
    assign fl_word_o     = s.flash_word_in_page;
    assign flash_erase_o = s.erase;
    assign cal_load_o    = s.cal_load;
    assign cal_idx_o     = s.cal_idx;
    assign reg_rdata_o   = s.rrd;

endmodule // mem_prot

// >>> design/mem_prot_pkg.sv
// Constants and types for the memory map and flash protection block
package mem_prot_pkg;

    // Flash word-address tops, larger variant
    localparam logic [15:0] APP_TOP_L    = 16'h37ff;
    localparam logic [15:0] TBL_TOP_L    = 16'h3fff;
    localparam logic [15:0] BOOT_TOP_L   = 16'h47ff;
    // Flash word-address tops, smaller variant
    localparam logic [15:0] APP_TOP_S    = 16'h17ff;
    localparam logic [15:0] TBL_TOP_S    = 16'h1fff;
    localparam logic [15:0] BOOT_TOP_S   = 16'h27ff;
    // Flash word and page split
    localparam int          FLASH_WORD_W = 16;
    localparam int          FLASH_WORD_IN_PAGE_W      = 7;
    localparam int          FLASH_PAGE_NUMBER_W      = 9;

    // Data space map
    localparam logic [15:0] IO_TOP       = 16'h0fff;
    localparam logic [15:0] EE_BASE      = 16'h1000;
    localparam logic [15:0] EE_TOP       = 16'h13ff;
    localparam logic [15:0] SRAM_BASE    = 16'h2000;
    localparam logic [15:0] SRAM_TOP_L   = 16'h2fff;
    localparam logic [15:0] SRAM_TOP_S   = 16'h27ff;
    localparam logic [15:0] BIT_IO_TOP   = 16'h001f;
    localparam logic [15:0] GP_TOP       = 16'h000f;
    localparam int          SHORT_IO_W   = 6;
    localparam int          EEPROM_BYTE_IN_PAGE_W     = 5;

    // Access lengths in clock cycles
    localparam logic [1:0]  IO_CYC       = 2'h1;
    localparam logic [1:0]  SRAM_WR_CYC  = 2'h1;
    localparam logic [1:0]  SRAM_RD_CYC  = 2'h2;
    localparam logic [1:0]  EE_LD_CYC    = 2'h1;
    localparam logic [1:0]  EE_RD_CYC    = 2'h3;
    localparam logic [1:0]  EE_BURST_CYC = 2'h2;

    // Register indices on the software port
    localparam logic [3:0]  REG_LOCK     = 4'h0;
    localparam logic [3:0]  REG_FUSE0    = 4'h1;
    localparam logic [3:0]  REG_FUSE1    = 4'h2;
    localparam logic [3:0]  REG_CTRL     = 4'h3;
    localparam logic [3:0]  REG_ID0      = 4'h4;
    localparam logic [3:0]  REG_ID1      = 4'h5;
    localparam logic [3:0]  REG_ID2      = 4'h6;
    localparam logic [3:0]  REG_REV      = 4'h7;
    localparam logic [3:0]  REG_STAT     = 4'h8;

    // Reset values and field positions
    localparam logic [7:0]  LOCK_RST     = 8'hff;
    localparam logic [7:0]  FUSE_RST     = 8'hff;
    localparam int          LK_APP       = 0;
    localparam int          LK_TBL       = 2;
    localparam int          LK_BOOT      = 4;
    localparam int          LK_WR        = 0;
    localparam int          LK_RD        = 1;
    localparam int          CTRL_EE_MAP  = 0;
    localparam int          STAT_CAL     = 0;
    localparam int          STAT_ERASE   = 1;

    typedef enum logic [1:0] {RG_APP = 2'b00, RG_TBL = 2'b01,
                              RG_BOOT = 2'b10, RG_NONE = 2'b11} region_t;
    typedef enum logic [1:0] {SP_MAIN = 2'b00, SP_USIG = 2'b01,
                              SP_PSIG = 2'b10, SP_FUSE = 2'b11} space_t;
    typedef enum logic [1:0] {FC_READ = 2'b00, FC_WRITE = 2'b01,
                              FC_ERASE = 2'b10} fcmd_t;
    typedef enum logic [1:0] {T_NONE = 2'b00, T_IO = 2'b01,
                              T_EE = 2'b10, T_SRAM = 2'b11} dtgt_t;
    typedef enum logic [1:0] {OP_NONE = 2'b00, OP_SET = 2'b01,
                              OP_CLR = 2'b10, OP_TEST = 2'b11} dop_t;
    typedef enum logic [1:0] {M_CAL = 2'b00, M_RUN = 2'b01,
                              M_ERASE = 2'b10} mstate_t;

endpackage

// >>> bench/mem_far.sv
// Far-side model: I/O, EEPROM and SRAM arrays plus the flash array eraser
`timescale 1ns/1ps
module mem_far (
    input  wire logic        clk_i,
    input  wire logic        io_i,
    input  wire logic        ee_i,
    input  wire logic        sram_i,
    input  wire logic        we_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        erase_i,
    output logic [7:0]       rdata_o,
    output logic             done_o
);
    logic [7:0]  mem [0:16383];
    logic [7:0]  junk = 8'h00;
    logic [2:0]  ecnt = 3'h0;
    logic [13:0] ix;
    logic        sel;
    // Bank chosen by the strobe
    assign sel = io_i | ee_i | sram_i;
    assign ix = {ee_i, sram_i, addr_i[11:0]};
    // Idle bus churns, so stale data can never pass for a read
    assign rdata_o = sel ? mem[ix] : junk;
    // Wipe takes a few cycles so locks can be seen held meanwhile
    assign done_o = (ecnt == 3'h5);
    always @(posedge clk_i)
    begin
        junk <= ~junk + 8'h5b;
        if (sel & we_i)
            mem[ix] <= wdata_i;
        ecnt <= erase_i ? ecnt + 3'h1 : 3'h0;
    end
endmodule // mem_far

// >>> bench/mem_prot_sva.sv
// Timing and protection checker for the memory map block
`timescale 1ns/1ps
module mem_prot_sva (
    input wire logic clk_i, rst_n_i, dat_re_i, dat_we_i, dat_short_i,
    input wire logic dat_burst_i, dat_busy_o, dat_done_o, dat_err_o,
    input wire logic [1:0] dat_op_i, fl_cmd_i, fl_space_i,
    input wire logic [15:0] dat_addr_i, fl_addr_i, fl_pc_i,
    input wire logic [7:0] dat_rdata_o,
    input wire logic tgt_io_o, tgt_ee_o, tgt_sram_o, fl_req_i, fl_prog_i,
    input wire logic fl_ok_o, fl_deny_o,
    input wire logic [8:0] fl_page_o,
    input wire logic [6:0] fl_word_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic go;
    // Long-form request taken while not busy
    assign go = (dat_re_i | dat_we_i) & !dat_busy_o & !dat_short_i;
    property p_sram_rd;
        go & dat_re_i & dat_op_i == 2'h0 & dat_addr_i inside {[16'h2000:16'h2fff]}
        |=> tgt_sram_o [*2] ##1 (dat_done_o & !tgt_sram_o);
    endproperty
    a_sram_rd: assert property (p_sram_rd) else $error("sram read length wrong");
    property p_io;
        go & dat_op_i == 2'h0 & dat_addr_i inside {[16'h0010:16'h0fff]}
        |=> tgt_io_o ##1 (dat_done_o & !tgt_io_o);
    endproperty
    a_io: assert property (p_io) else $error("io access length wrong");
    property p_ee_rd;
        go & dat_re_i & !dat_burst_i & dat_addr_i inside {[16'h1000:16'h13ff]} ##1 tgt_ee_o
        |=> tgt_ee_o ##1 tgt_ee_o ##1 dat_done_o;
    endproperty
    a_ee_rd: assert property (p_ee_rd) else $error("eeprom read length wrong");
    property p_gap;
        go & dat_re_i & dat_addr_i inside {[16'h1400:16'h1fff]}
        |=> !(tgt_io_o | tgt_ee_o | tgt_sram_o) ##1
            (dat_done_o & !(tgt_io_o | tgt_ee_o | tgt_sram_o) & dat_rdata_o == 8'h00);
    endproperty
    a_gap: assert property (p_gap) else $error("reserved gap not empty");
    property p_bit_err;
        go & dat_op_i != 2'h0 & dat_addr_i > 16'h001f |=> dat_err_o & !dat_busy_o;
    endproperty
    a_bit_err: assert property (p_bit_err) else $error("bit op not refused");
    property p_fl_split;
        fl_req_i |=> fl_page_o == $past(fl_addr_i[15:7]) & fl_word_o == $past(fl_addr_i[6:0]);
    endproperty
    a_fl_split: assert property (p_fl_split) else $error("page split wrong");
    property p_store_app;
        fl_req_i & fl_cmd_i == 2'h1 & fl_space_i == 2'h0 & !fl_prog_i & fl_pc_i < 16'h4000
        |=> fl_deny_o & !fl_ok_o;
    endproperty
    a_store_app: assert property (p_store_app) else $error("store outside boot");
    property p_fuse_sw;
        fl_req_i & !fl_prog_i & fl_space_i[1] & fl_cmd_i != 2'h0 |=> fl_deny_o;
    endproperty
    a_fuse_sw: assert property (p_fuse_sw) else $error("row write allowed");
    c_ok: cover property (fl_ok_o);
    c_err: cover property (dat_err_o);
    c_sram: cover property (tgt_sram_o ##1 dat_done_o);
endmodule // mem_prot_sva
bind mem_prot mem_prot_sva chk (.*);

// >>> bench/test_mem_prot.sv
// Self-checking bench for the memory map and protection block
`timescale 1ns/1ps
module test_mem_prot;
    logic clk_i, rst_n_i, dat_re_i, dat_we_i, dat_short_i, dat_burst_i, fl_req_i, fl_prog_i;
    logic pgm_lock_we_i, pgm_fuse_we_i, pgm_fuse_sel_i, chip_erase_i, erase_done_i;
    logic reg_we_i, reg_re_i, dat_busy_o, dat_done_o, dat_err_o, tgt_io_o, tgt_ee_o;
    logic tgt_sram_o, tgt_we_o, fl_ok_o, fl_deny_o, flash_erase_o, cal_load_o;
    logic [1:0]  dat_op_i, fl_cmd_i, fl_space_i, tgt_op_o;
    logic [2:0]  dat_bit_i, tgt_bit_o;
    logic [3:0]  reg_addr_i;
    logic [6:0]  fl_word_o;
    logic [8:0]  fl_page_o;
    logic [7:0]  dat_wdata_i, dat_rdata_o, tgt_wdata_o, tgt_rdata_i, pgm_data_i;
    logic [7:0]  cal_idx_o, reg_wdata_i, reg_rdata_o, d;
    logic [15:0] dat_addr_i, tgt_addr_o, fl_addr_i, fl_pc_i, a;
    logic [31:0] seed = 32'h9546;
    int n_errors = 0;
    int tests_run = 0;
    int i;
    mem_prot dut (.*);
    mem_far far (.clk_i(clk_i), .io_i(tgt_io_o), .ee_i(tgt_ee_o), .sram_i(tgt_sram_o),
        .we_i(tgt_we_o), .addr_i(tgt_addr_o), .wdata_i(tgt_wdata_o),
        .erase_i(flash_erase_o), .rdata_o(tgt_rdata_i), .done_o(erase_done_i));
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Register strobes last one cycle; read data only in the next cycle
    task automatic reg_wr(input logic [3:0] ad, input logic [7:0] v);
        reg_addr_i <= ad;
        reg_wdata_i <= v;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [3:0] ad, input logic [7:0] e);
        reg_addr_i <= ad;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1;
        chk(reg_rdata_o, e);
    endtask
    // Verdict stands in the cycle after the check request
    task automatic fl(input logic [1:0] c, input logic [1:0] s, input logic [15:0] ad,
                      input logic [15:0] pc, input logic p, input logic e);
        {fl_req_i, fl_cmd_i, fl_space_i, fl_addr_i, fl_pc_i, fl_prog_i} <= {1'b1, c, s, ad, pc, p};
        @(posedge clk_i);
        fl_req_i <= 1'b0;
        #1;
        chk({6'h0, fl_deny_o, fl_ok_o}, {6'h0, !e, e});
    endtask
    // One data access, waiting for done or refusal under a bound
    task automatic acc(input logic w, input logic [15:0] ad, input logic [7:0] v,
                       input logic [1:0] op);
        {dat_we_i, dat_re_i, dat_addr_i, dat_wdata_i, dat_op_i} <= {w, !w, ad, v, op};
        @(posedge clk_i);
        {dat_we_i, dat_re_i} <= 2'b00;
        #1;
        for (i = 0; dat_done_o !== 1'b1 && dat_err_o !== 1'b1; i++)
        begin
            if (i == 8)
            begin
                n_errors++;
                stop_test();
            end
            @(posedge clk_i);
            #1;
        end
    endtask
    initial
    begin
        {dat_re_i, dat_we_i, dat_short_i, dat_burst_i, fl_req_i, fl_prog_i, pgm_lock_we_i} = '0;
        {pgm_fuse_we_i, pgm_fuse_sel_i, chip_erase_i, reg_we_i, reg_re_i, dat_op_i} = '0;
        {dat_bit_i, fl_cmd_i, fl_space_i, reg_addr_i, dat_wdata_i, pgm_data_i} = '0;
        {reg_wdata_i, dat_addr_i, fl_addr_i, fl_pc_i} = '0;
        rst_n_i = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Calibration copy runs CAL_N cycles after release
        repeat (10) @(posedge clk_i);
        #1;
        reg_rd(mem_prot_pkg::REG_STAT, 8'h00);
        reg_rd(mem_prot_pkg::REG_LOCK, 8'hff);
        reg_rd(4'hf, 8'h00);
        reg_wr(mem_prot_pkg::REG_FUSE0, 8'h00);
        reg_rd(mem_prot_pkg::REG_FUSE0, 8'hff);
        {pgm_fuse_we_i, pgm_data_i} <= {1'b1, 8'h5f};
        @(posedge clk_i);
        pgm_fuse_we_i <= 1'b0;
        #1;
        reg_rd(mem_prot_pkg::REG_FUSE0, 8'h5f);
        $display("register test done");
        fl(2'h1, 2'h0, 16'h0100, 16'h0200, 1'b0, 1'b0);
        fl(2'h1, 2'h0, 16'h4700, 16'h4010, 1'b0, 1'b1);
        fl(2'h0, 2'h0, 16'h4800, 16'h0000, 1'b0, 1'b0);
        fl(2'h1, 2'h2, 16'h0000, 16'h4000, 1'b1, 1'b0);
        fl(2'h2, 2'h3, 16'h0000, 16'h4000, 1'b1, 1'b0);
        fl(2'h1, 2'h3, 16'h0000, 16'h4000, 1'b0, 1'b0);
        fl(2'h1, 2'h1, 16'h0005, 16'h4000, 1'b0, 1'b1);
        reg_wr(mem_prot_pkg::REG_LOCK, 8'hfd);
        reg_wr(mem_prot_pkg::REG_LOCK, 8'hff);
        reg_rd(mem_prot_pkg::REG_LOCK, 8'hfd);
        fl(2'h0, 2'h0, 16'h0100, 16'h0000, 1'b1, 1'b0);
        fl(2'h0, 2'h0, 16'h3900, 16'h0000, 1'b1, 1'b1);
        chip_erase_i <= 1'b1;
        @(posedge clk_i);
        chip_erase_i <= 1'b0;
        #1;
        reg_rd(mem_prot_pkg::REG_LOCK, 8'hfd);
        for (i = 0; flash_erase_o !== 1'b0; i++)
        begin
            if (i == 20)
            begin
                n_errors++;
                stop_test();
            end
            @(posedge clk_i);
            #1;
        end
        reg_rd(mem_prot_pkg::REG_LOCK, 8'hff);
        reg_rd(mem_prot_pkg::REG_FUSE0, 8'h5f);
        $display("flash test done");
        acc(1'b1, 16'h0005, 8'ha5, 2'h0);
        dat_bit_i <= 3'h1;
        acc(1'b0, 16'h0005, 8'h00, 2'h1);
        acc(1'b0, 16'h0005, 8'h00, 2'h0);
        chk(dat_rdata_o, 8'ha7);
        acc(1'b0, 16'h0025, 8'h00, 2'h1);
        chk({7'h0, dat_err_o}, 8'h01);
        acc(1'b1, 16'h1800, 8'h33, 2'h0);
        acc(1'b0, 16'h1800, 8'h00, 2'h0);
        chk(dat_rdata_o, 8'h00);
        acc(1'b0, 16'h1010, 8'h00, 2'h0);
        chk(dat_rdata_o, 8'h00);
        reg_wr(mem_prot_pkg::REG_CTRL, 8'h01);
        acc(1'b1, 16'h1010, 8'h3c, 2'h0);
        acc(1'b0, 16'h1010, 8'h00, 2'h0);
        chk(dat_rdata_o, 8'h3c);
        // Random write and read-back across I/O and SRAM
        repeat (20)
        begin
            a = (seed[0] ? 16'h2000 : 16'h0100) + {6'h0, seed[9:0]};
            d = xs();
            acc(1'b1, a, d, 2'h0);
            acc(1'b0, a, 8'h00, 2'h0);
            chk(dat_rdata_o, d);
        end
        $display("data test done");
        stop_test();
    end
endmodule // test_mem_prot
